//--- include/hsl_consts.svh
`ifndef HSL_CONSTS_SVH
`define HSL_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HSL_OFS_MODE 8'h00
`define HSL_OFS_CTRL 8'h04
`define HSL_OFS_SADR0 8'h08
`define HSL_OFS_SADR1 8'h0c
`define HSL_OFS_IDLE 8'h10
`define HSL_OFS_CMD 8'h14
`define HSL_OFS_STAT 8'h18
`define HSL_OFS_TXD 8'h1c
`define HSL_OFS_RXD 8'h20
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define HSL_MODE_CRC_BIT 4
`define HSL_MODE_ADDR_LSB 8
`define HSL_CTRL_UDRN_BIT 0
`define HSL_CTRL_GOP_BIT 1
`define HSL_CTRL_IE_LSB 4
`define HSL_CMD_TXEN 0
`define HSL_CMD_TXRST 1
`define HSL_CMD_ABORT 2
`define HSL_CMD_EOM 3
`define HSL_ST_SHORT_FRAME_FLAG 0
`define HSL_ST_EOM 1
`define HSL_ST_ABT 2
`define HSL_ST_UDRN 3
`define HSL_PROT_LOOP 3'h3
`define HSL_PROT_RST 3'h2
`define HSL_IDLE_RST 8'h7e
`define HSL_AM_SA1 2'h1
`define HSL_AM_SA2 2'h2
`define HSL_AM_DUAL 2'h3
// ----------------------------------------
// Line patterns and frame length limits
// ----------------------------------------
`define HSL_PAT_FLAG 8'h7e
`define HSL_PAT_ABORT 8'h7f
`define HSL_PAT_ONES 8'hff
`define HSL_ADDR_GLOBAL 8'hff
`define HSL_STUFF_ONES 3'h5
`define HSL_LEN_NONE 6'h08
`define HSL_LEN_SHORT 6'h20
`define HSL_LEN_LONG 6'h28
`endif

//--- include/hsl_pkg.sv
package hsl_pkg;
	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_FLUSH} hsl_rx_st_t;
	typedef enum logic [2:0] {
		TX_DIS, TX_RTX, TX_IDLE, TX_OPEN, TX_CHAR, TX_CLOSE, TX_ABORT
	} hsl_tx_st_t;
	// Receive buffer entry: character with its status
	typedef struct packed {
		logic abort_seen_flag;
		logic short_frame_flag;
		logic end_of_frame_flag;
		logic [7:0] data;
	} hsl_rx_ent_t;
	// ----------------------------------------
	// State of the station, apart from the receive buffer contents
	// ----------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [2:0] prot;
		logic crc_en;
		logic [1:0] am;
		logic udrn_sel;
		logic go_on_poll;
		logic [2:0] ie;
		logic [7:0] sa0;
		logic [7:0] sa1;
		logic [7:0] idle;
		logic short_frame_flag_f;
		logic eom_f;
		logic abt_f;
		logic udrn_f;
		logic irq;
		hsl_rx_st_t rx_st;
		logic [7:0] hist;
		logic [2:0] ones;
		logic [7:0] dly;
		logic [3:0] fill;
		logic [5:0] len;
		logic [7:0] asm;
		logic [2:0] nbit;
		logic [2:0] nbyte;
		logic [7:0] a1;
		logic [1:0] pn;
		logic [2:0][7:0] pipe;
		logic [1:0] fl;
		logic fl_short;
		logic fl_abt;
		logic fl_hunt;
		hsl_tx_st_t tx_st;
		logic [7:0] tsh;
		logic [2:0] tcnt;
		logic [2:0] tones;
		logic [7:0] tbuf;
		logic tbuf_v;
		logic eom_pend;
		logic txd;
	} hsl_state_t;
endpackage

//--- design/hsl_rx_queue.sv
`timescale 1ns/1ps
module hsl_rx_queue #(
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire hsl_pkg::hsl_rx_ent_t in_ent_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output hsl_pkg::hsl_rx_ent_t out_ent_o,
	input wire logic out_ready_i
);
	import hsl_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = DEPTH[AW:0];

	// Depth must be a power of two, two or more
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
		$error("hsl_rx_queue: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		hsl_rx_ent_t [DEPTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} hsl_rxq_state_t;

	hsl_rxq_state_t q_q;
	hsl_rxq_state_t q_d;
	logic wr;
	logic rd;

	// Handshake flags
	assign in_ready_o = q_q.cnt != FULL;
	assign out_valid_o = q_q.cnt != '0;
	assign out_ent_o = q_q.mem[q_q.rp];
	assign wr = in_valid_i & in_ready_o;
	assign rd = out_valid_o & out_ready_i;

	// Pointer and count update; a full queue drops the write
	always_comb begin
		q_d = q_q;
		if (wr) begin
			q_d.mem[q_q.wp] = in_ent_i;
			q_d.wp = q_q.wp + 1'b1;
		end
		if (rd) begin
			q_d.rp = q_q.rp + 1'b1;
		end
		q_d.cnt = q_q.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end
endmodule

//--- design/hsl_station.sv
// What this block does
// - Address check mode from two-bit field, compared against one or both address registers.
// - Single address modes accept programmed address or all-ones global address.
// - 1-8 bit frames store nothing; 9-23 store partial only without CRC check.
// - 24-31 bit frames store partial data, tag short status, set short flag.
// - 32-39 bits short only in single address 2 and dual; 40+ normal.
// - Short flag also sets end-of-frame flag and raises interrupt if enabled.
// - Short frame with nothing stored leaves short flag clear.
// - Abort command starts abort transmission unless the transmitter is disabled or repeating in loop mode.
// - Underrun with underrun select zero enters abort transmit state.
// - Abort sends eight ones, discards shift register and buffer, then idles.
// - Zero plus seven ones is an abort: flag wait, interrupt if enabled.
// - Abort mid-frame stores data, dropping FCS bytes if CRC on; abort flag set.
// - Protocol field selects loop mode, otherwise behaving like HDLC.
// - Secondary treats go-ahead pattern after closing flag as transmit request.
// - Secondary normally repeats each received bit on its own bit strobe, one clock later.
// - Software sets go-on-poll; secondary waits for next go-ahead to transmit.
// - Go-ahead with go-on-poll set: last one becomes zero, then frames sent.
// - With no transmit data, secondary sends idle pattern register repeatedly.
// - After its data the secondary sends one flag and resumes repeating.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "hsl_consts.svh"
module hsl_station #(
	parameter int RXQ_DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic bit_stb_i,
	input wire logic rxd_i,
	output logic txd_o,
	output logic irq_o
);
	import hsl_pkg::*;

	hsl_state_t s_q;
	hsl_state_t s_d;
	logic [7:0] adr;
	logic bus_req;
	logic wr;
	logic b;
	logic [7:0] hist_n;
	logic stuffed;
	logic is_flag;
	logic is_abort;
	logic [7:0] bt;
	logic is_short;
	logic [1:0] nfl;
	logic loop;
	logic push;
	logic push_rdy;
	hsl_rx_ent_t push_ent;
	logic pop;
	logic q_valid;
	hsl_rx_ent_t q_ent;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Address acceptance per check mode
	function automatic logic addr_ok(input logic [1:0] am, input logic [7:0] a1,
			input logic [7:0] a2, input logic [7:0] s0, input logic [7:0] s1);
		logic g1;
		g1 = (a1 == `HSL_ADDR_GLOBAL);
		case (am)
			`HSL_AM_SA1: addr_ok = (a1 == s0) || g1;
			`HSL_AM_SA2: addr_ok = (a2 == s1) || (a2 == `HSL_ADDR_GLOBAL);
			`HSL_AM_DUAL: addr_ok = ((a1 == s0) && (a2 == s1))
				|| (g1 && ((a2 == s1) || (a2 == `HSL_ADDR_GLOBAL)));
			default: addr_ok = 1'b1;
		endcase
	endfunction

	// Next step at a character boundary: data, closing flag or underrun
	function automatic hsl_state_t next_char(input hsl_state_t s);
		hsl_state_t n;
		n = s;
		n.tcnt = 3'h0;
		if (s.tbuf_v) begin
			n.tx_st = TX_CHAR;
			n.tsh = s.tbuf;
			n.tbuf_v = 1'b0;
		end else if (s.eom_pend) begin
			n.tx_st = TX_CLOSE;
			n.tsh = `HSL_PAT_FLAG;
			n.eom_pend = 1'b0;
		end else begin
			n.udrn_f = 1'b1;
			if (!s.udrn_sel) begin
				n.tx_st = TX_ABORT;
				n.tsh = `HSL_PAT_ONES;
				n.tbuf_v = 1'b0;
			end else begin
				n.tx_st = TX_CLOSE;
				n.tsh = `HSL_PAT_FLAG;
			end
		end
		return n;
	endfunction

	// ----------------------------------------
	// Receive buffer
	// ----------------------------------------
	hsl_rx_queue #(.DEPTH(RXQ_DEPTH)) u_rxq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ent_i(push_ent),
		.in_ready_o(push_rdy),
		.out_valid_o(q_valid),
		.out_ent_o(q_ent),
		.out_ready_i(pop)
	);

	// Decode helpers
	assign adr = {wb_adr_i[7:2], 2'b00};
	assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr = bus_req & wb_we_i;
	assign b = rxd_i;
	assign hist_n = {s_q.hist[6:0], b};
	assign stuffed = ~b & (s_q.ones == `HSL_STUFF_ONES);
	assign is_flag = hist_n == `HSL_PAT_FLAG;
	assign is_abort = hist_n == `HSL_PAT_ABORT;
	assign bt = {s_q.dly[7], s_q.asm[7:1]};
	assign loop = s_q.prot == `HSL_PROT_LOOP;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		push = 1'b0;
		push_ent = '0;
		pop = 1'b0;
		is_short = 1'b0;
		nfl = 2'h0;
		s_d.ack = bus_req;
		s_d.rdat = '0;

		// Register reads; unmapped reads return zero
		if (bus_req && !wb_we_i) begin
			if (adr == `HSL_OFS_MODE) begin
				s_d.rdat = {22'h0, s_q.am, 3'h0, s_q.crc_en, 1'b0, s_q.prot};
			end else if (adr == `HSL_OFS_CTRL) begin
				s_d.rdat = {25'h0, s_q.ie, 2'h0, s_q.go_on_poll, s_q.udrn_sel};
			end else if (adr == `HSL_OFS_SADR0) begin
				s_d.rdat = {24'h0, s_q.sa0};
			end else if (adr == `HSL_OFS_SADR1) begin
				s_d.rdat = {24'h0, s_q.sa1};
			end else if (adr == `HSL_OFS_IDLE) begin
				s_d.rdat = {24'h0, s_q.idle};
			end else if (adr == `HSL_OFS_STAT) begin
				s_d.rdat = {26'h0, ~s_q.tbuf_v, q_valid, s_q.udrn_f, s_q.abt_f,
					s_q.eom_f, s_q.short_frame_flag_f};
			end else if (adr == `HSL_OFS_RXD) begin
				s_d.rdat = {21'h0, q_ent};
				pop = q_valid;
			end
		end

		// Register writes on the low byte lane; address mode on byte lane 1
		if (wr && wb_sel_i[0]) begin
			if (adr == `HSL_OFS_MODE) begin
				s_d.prot = wb_dat_i[2:0];
				s_d.crc_en = wb_dat_i[`HSL_MODE_CRC_BIT];
			end else if (adr == `HSL_OFS_CTRL) begin
				s_d.udrn_sel = wb_dat_i[`HSL_CTRL_UDRN_BIT];
				s_d.go_on_poll = wb_dat_i[`HSL_CTRL_GOP_BIT];
				s_d.ie = wb_dat_i[`HSL_CTRL_IE_LSB +: 3];
			end else if (adr == `HSL_OFS_SADR0) begin
				s_d.sa0 = wb_dat_i[7:0];
			end else if (adr == `HSL_OFS_SADR1) begin
				s_d.sa1 = wb_dat_i[7:0];
			end else if (adr == `HSL_OFS_IDLE) begin
				s_d.idle = wb_dat_i[7:0];
			end else if (adr == `HSL_OFS_STAT) begin
				// Write one to clear; later sets in this cycle win
				if (wb_dat_i[`HSL_ST_SHORT_FRAME_FLAG]) s_d.short_frame_flag_f = 1'b0;
				if (wb_dat_i[`HSL_ST_EOM]) s_d.eom_f = 1'b0;
				if (wb_dat_i[`HSL_ST_ABT]) s_d.abt_f = 1'b0;
				if (wb_dat_i[`HSL_ST_UDRN]) s_d.udrn_f = 1'b0;
			end else if (adr == `HSL_OFS_CMD) begin
				if (wb_dat_i[`HSL_CMD_TXRST]) begin
					s_d.tx_st = TX_DIS;
					s_d.tbuf_v = 1'b0;
					s_d.eom_pend = 1'b0;
					s_d.txd = 1'b1;
				end else begin
					if (wb_dat_i[`HSL_CMD_TXEN] && s_q.tx_st == TX_DIS) begin
						s_d.tx_st = loop ? TX_RTX : TX_IDLE;
						s_d.tcnt = 3'h0;
					end
					if (wb_dat_i[`HSL_CMD_ABORT] && s_q.tx_st != TX_DIS
							&& s_q.tx_st != TX_RTX) begin
						s_d.tx_st = TX_ABORT;
						s_d.tsh = `HSL_PAT_ONES;
						s_d.tcnt = 3'h0;
						s_d.tbuf_v = 1'b0;
					end
					if (wb_dat_i[`HSL_CMD_EOM]) s_d.eom_pend = 1'b1;
				end
			end else if (adr == `HSL_OFS_TXD) begin
				if (!s_q.tbuf_v) begin
					s_d.tbuf = wb_dat_i[7:0];
					s_d.tbuf_v = 1'b1;
				end
			end
		end
		if (wr && wb_sel_i[1] && adr == `HSL_OFS_MODE) begin
			s_d.am = wb_dat_i[`HSL_MODE_ADDR_LSB +: 2];
		end

		// Flush the held characters of an ended frame, one per cycle
		if (s_q.rx_st == RX_FLUSH) begin
			push = 1'b1;
			push_ent.data = s_q.pipe[0];
			s_d.pipe = {8'h00, s_q.pipe[2], s_q.pipe[1]};
			s_d.fl = s_q.fl - 2'h1;
			if (s_q.fl == 2'h1) begin
				push_ent.end_of_frame_flag = 1'b1;
				push_ent.short_frame_flag = s_q.fl_short;
				push_ent.abort_seen_flag = s_q.fl_abt;
				s_d.eom_f = 1'b1;
				if (s_q.fl_short) s_d.short_frame_flag_f = 1'b1;
				s_d.rx_st = s_q.fl_hunt ? RX_HUNT : RX_FRAME;
			end
		end

		// Receive bit: zero deletion, 8-bit delay to hide flags, assembly
		if (bit_stb_i) begin
			s_d.hist = hist_n;
			s_d.ones = b ? ((s_q.ones == 3'h7) ? 3'h7 : s_q.ones + 3'h1) : 3'h0;
			if (!stuffed) begin
				s_d.dly = {s_q.dly[6:0], b};
				if (s_q.fill != 4'h8) begin
					s_d.fill = s_q.fill + 4'h1;
				end else if (s_q.rx_st == RX_FRAME) begin
					if (s_q.len != `HSL_LEN_LONG) s_d.len = s_q.len + 6'h01;
					s_d.asm = bt;
					s_d.nbit = s_q.nbit + 3'h1;
					if (s_q.nbit == 3'h7) begin
						if (s_q.nbyte != 3'h7) s_d.nbyte = s_q.nbyte + 3'h1;
						if (s_q.nbyte == 3'h0) s_d.a1 = bt;
						// Three characters held back so FCS can be dropped
						if (s_q.pn == 2'h3) begin
							push = 1'b1;
							push_ent.data = s_q.pipe[0];
							s_d.pipe = {bt, s_q.pipe[2], s_q.pipe[1]};
						end else begin
							s_d.pipe[s_q.pn] = bt;
							s_d.pn = s_q.pn + 2'h1;
						end
						if ((s_q.am == `HSL_AM_SA1 && s_q.nbyte == 3'h0
								&& !addr_ok(s_q.am, bt, 8'h00, s_q.sa0, s_q.sa1))
								|| (s_q.am[1] && s_q.nbyte == 3'h1
								&& !addr_ok(s_q.am, s_q.a1, bt, s_q.sa0, s_q.sa1))) begin
							s_d.rx_st = RX_HUNT;
						end
					end
				end
			end
			if (is_flag) s_d.fill = 4'h0;
			if (is_abort && s_q.rx_st != RX_HUNT) s_d.abt_f = 1'b1;
			if ((is_flag || is_abort) && s_d.rx_st == RX_FRAME) begin
				is_short = (s_d.len < `HSL_LEN_SHORT)
					|| ((s_d.len < `HSL_LEN_LONG) && s_d.am[1]);
				// CRC on: the last two held characters are FCS
				nfl = s_d.crc_en ? ((s_d.pn == 2'h3) ? 2'h1 : 2'h0) : s_d.pn;
				if (is_short && s_d.len <= `HSL_LEN_NONE) nfl = 2'h0;
				if (s_d.len != 6'h00 && nfl != 2'h0) begin
					s_d.rx_st = RX_FLUSH;
				end else begin
					s_d.rx_st = is_abort ? RX_HUNT : RX_FRAME;
				end
				s_d.fl = nfl;
				s_d.fl_short = is_short;
				s_d.fl_abt = is_abort;
				s_d.fl_hunt = is_abort;
			end else if (is_flag && s_d.rx_st == RX_HUNT) begin
				s_d.rx_st = RX_FRAME;
			end
			if (is_flag || is_abort) begin
				s_d.len = 6'h00;
				s_d.nbit = 3'h0;
				s_d.nbyte = 3'h0;
				s_d.pn = 2'h0;
			end
		end

		// Transmit bit
		if (bit_stb_i) begin
			case (s_d.tx_st)
				TX_DIS: begin
					s_d.txd = 1'b1;
				end
				TX_RTX: begin
					s_d.txd = b;
					if (s_q.go_on_poll && is_abort) begin
						s_d.txd = 1'b0;
						s_d.tx_st = TX_IDLE;
						s_d.tcnt = 3'h0;
					end
				end
				TX_IDLE: begin
					s_d.txd = loop ? s_q.idle[s_q.tcnt] : 1'b1;
					s_d.tcnt = s_q.tcnt + 3'h1;
					if (loop && !s_q.go_on_poll) begin
						s_d.tx_st = TX_RTX;
					end else if (s_d.tbuf_v && (!loop || s_q.tcnt == 3'h7)) begin
						s_d.tx_st = TX_OPEN;
						s_d.tsh = `HSL_PAT_FLAG;
						s_d.tcnt = 3'h0;
					end
				end
				TX_OPEN, TX_CLOSE, TX_ABORT: begin
					if (s_d.tx_st == TX_CLOSE && s_d.tones == `HSL_STUFF_ONES) begin
						s_d.txd = 1'b0;
						s_d.tones = 3'h0;
					end else begin
						s_d.txd = s_d.tsh[0];
						s_d.tsh = {1'b0, s_d.tsh[7:1]};
						s_d.tones = 3'h0;
						s_d.tcnt = s_d.tcnt + 3'h1;
						if (s_d.tcnt == 3'h0) begin
							if (s_d.tx_st == TX_OPEN) begin
								s_d = next_char(s_d);
							end else if (s_d.tx_st == TX_CLOSE) begin
								s_d.tx_st = loop ? TX_RTX : TX_IDLE;
							end else begin
								s_d.tx_st = TX_IDLE;
								s_d.tbuf_v = 1'b0;
							end
						end
					end
				end
				default: begin
					// Character with zero insertion after five ones
					if (s_d.tones == `HSL_STUFF_ONES) begin
						s_d.txd = 1'b0;
						s_d.tones = 3'h0;
					end else begin
						s_d.txd = s_d.tsh[0];
						s_d.tones = s_d.tsh[0] ? s_d.tones + 3'h1 : 3'h0;
						s_d.tsh = {1'b0, s_d.tsh[7:1]};
						s_d.tcnt = s_d.tcnt + 3'h1;
						if (s_d.tcnt == 3'h0) s_d = next_char(s_d);
					end
				end
			endcase
		end

		// Interrupt request from flags and enables
		s_d.irq = |({s_d.abt_f, s_d.eom_f, s_d.short_frame_flag_f} & s_d.ie);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.txd <= 1'b1;
			s_q.idle <= `HSL_IDLE_RST;
			s_q.prot <= `HSL_PROT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdat;
	assign txd_o = s_q.txd;
	assign irq_o = s_q.irq;
endmodule

//--- testbench/hsl_station_properties.sv
`timescale 1ns/1ps
module hsl_station_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic bit_stb_i,
	input wire logic rxd_i,
	input wire logic txd_o,
	input wire logic irq_o
);
	logic [2:0] ie_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the interrupt enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_q <= 3'h0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:2] == 6'h01) begin
			ie_q <= wb_sel_i[0] ? wb_dat_i[6:4] : ie_q;
		end
	end
	// ------
	// Bus and line checks
	// ------
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_txd_on_strobe: assert property (
		!$stable(txd_o) |-> $past(bit_stb_i) || $past(wb_cyc_i) || $past(rst_i))
		else $error("line moved off strobe");
	a_irq_fall_write: assert property (
		$fell(irq_o) |-> ($past(wb_cyc_i) && $past(wb_we_i)) || $past(rst_i))
		else $error("irq dropped by itself");
	a_irq_enabled: assert property (
		irq_o |-> ie_q != 3'h0 || $past(ie_q) != 3'h0)
		else $error("irq while disabled");
	a_reset_quiet: assert property ($fell(rst_i) |-> txd_o && !irq_o && !wb_ack_o)
		else $error("outputs not at rest");
endmodule

//--- testbench/hsl_remote.sv
`timescale 1ns/1ps
module hsl_remote (
	input wire logic clk_i,
	input wire logic txd_i,
	output logic rxd_o,
	output logic bit_stb_o
);
	logic seen_q[$];
	int ones = 0;
	initial begin
		rxd_o = 1'b1;
		bit_stb_o = 1'b0;
	end
	// One bit time: strobe, then record the repeated line
	task automatic put_bit(input logic b);
		@(posedge clk_i);
		rxd_o <= b;
		bit_stb_o <= 1'b1;
		@(posedge clk_i);
		bit_stb_o <= 1'b0;
		rxd_o <= ~b; // Inverted outside the strobe
		@(posedge clk_i);
		seen_q.push_back(txd_i);
		@(posedge clk_i);
	endtask
	// Octet LSB first, with zero insertion inside frames
	task automatic send(input logic [7:0] v, input logic stuff);
		for (int i = 0; i < 8; i++) begin
			put_bit(v[i]);
			ones = v[i] ? ones + 1 : 0;
			if (stuff && ones == 5) begin
				put_bit(1'b0);
				ones = 0;
			end
		end
	endtask
	// All-ones idle between frames
	task automatic idle(input int n);
		repeat (n) put_bit(1'b1);
	endtask
endmodule

//--- testbench/hsl_station_bench.sv
`timescale 1ns/1ps
module hsl_station_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic bit_stb_i;
	logic rxd_i;
	logic txd_o;
	logic irq_o;
	logic [31:0] q;
	logic [7:0] fb [5] = '{8'hff, 8'hff, 8'h81, 8'h42, 8'h24};
	// Case table: crc, address mode, octets, expected status
	logic [19:0] cs [7] = '{20'h0_0100, 20'h0_0213, 20'h1_0200, 20'h1_1313,
		20'h0_1412, 20'h0_2413, 20'h1_3512};
	int fails = 0;
	int checks_done = 0;
	always #2.5 clk_i = ~clk_i;
	hsl_station #(.RXQ_DEPTH(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.bit_stb_i(bit_stb_i), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
	hsl_remote peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .bit_stb_o(bit_stb_i));
	// ------
	// Tasks
	// ------
	task automatic results;
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checks_done++;
		if ((got & m) !== (exp & m)) begin
			$display("BAD %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		@(posedge clk_i);
		// Only the watchdog ends a wait for ack
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, exp, m);
	endtask
	task automatic frame(input int s, input int n);
		peer.send(8'h7e, 1'b0);
		for (int i = s; i < s + n; i++) begin
			peer.send(fb[i], 1'b1);
		end
		peer.send(8'h7e, 1'b0);
		peer.send(8'h7e, 1'b0);
		repeat (16) @(posedge clk_i);
	endtask
	// Empty the receive queue, clear the flags, confirm all but the underrun flag are gone
	task automatic drain;
		repeat (6) wb(1'b0, 8'h20, 32'h0000_0000);
		wb(1'b1, 8'h18, 32'h0000_000f);
		rd(8'h18, 32'h0000_0000, 32'h0000_0017);
	endtask
	// Eight line bits, oldest first, starting back entries from the end
	function automatic logic [31:0] tail(input int back);
		logic [31:0] t;
		t = 32'h0000_0000;
		for (int i = 0; i < 8; i++) begin
			t[i] = peer.seen_q[peer.seen_q.size() - back + i];
		end
		return t;
	endfunction
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk_i);
		fails++;
		results;
	end
	// ------
	// Main sequence
	// ------
	initial begin
		logic [31:0] v;
		v = 32'h0000_0000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h0000_0002, 32'hffff_ffff);
		rd(8'h10, 32'h0000_007e, 32'hffff_ffff);
		rd(8'h3c, 32'h0000_0000, 32'hffff_ffff);
		rd(8'h18, 32'h0000_0020, 32'h0000_003f);
		wb(1'b1, 8'h04, 32'h0000_0010);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, 8'h00, {22'h0, cs[i][13:12], 3'h0, cs[i][16], 4'h2});
			frame(0, int'(cs[i][11:8]));
			rd(8'h18, {27'h0, cs[i][4:0]}, 32'h0000_0013);
			chk({31'h0, irq_o}, {31'h0, cs[i][0]}, 32'h0000_0001);
			drain;
		end
		// Single address 1 against a programmed address, then a mismatch
		wb(1'b1, 8'h08, 32'h0000_0081);
		wb(1'b1, 8'h00, 32'h0000_0102);
		frame(2, 3);
		rd(8'h18, 32'h0000_0013, 32'h0000_0013);
		drain;
		wb(1'b1, 8'h08, 32'h0000_0018);
		frame(2, 3);
		rd(8'h18, 32'h0000_0000, 32'h0000_0013);
		drain;
		// Abort in mid-frame
		wb(1'b1, 8'h00, 32'h0000_0002);
		wb(1'b1, 8'h04, 32'h0000_0040);
		peer.send(8'h7e, 1'b0);
		for (int i = 2; i < 5; i++) begin
			peer.send(fb[i], 1'b1);
		end
		peer.send(8'hfe, 1'b0);
		frame(0, 0);
		rd(8'h18, 32'h0000_0004, 32'h0000_0004);
		chk({31'h0, irq_o}, 32'h0000_0001, 32'h0000_0001);
		drain;
		// Underrun with abort selected
		wb(1'b1, 8'h04, 32'h0000_0000);
		wb(1'b1, 8'h14, 32'h0000_0001);
		wb(1'b1, 8'h1c, 32'h0000_0000);
		peer.idle(40);
		rd(8'h18, 32'h0000_0028, 32'h0000_0028);
		chk(tail(8), 32'h0000_00ff, 32'h0000_00ff);
		chk(tail(23), 32'h0000_00ff, 32'h0000_00ff);
		drain;
		// Abort command while data waits
		wb(1'b1, 8'h04, 32'h0000_0001);
		wb(1'b1, 8'h1c, 32'h0000_0000);
		wb(1'b1, 8'h1c, 32'h0000_0000);
		wb(1'b1, 8'h14, 32'h0000_0004);
		peer.idle(24);
		rd(8'h18, 32'h0000_0020, 32'h0000_0028);
		chk(tail(8), 32'h0000_00ff, 32'h0000_00ff);
		// Underrun with closing flag selected
		wb(1'b1, 8'h1c, 32'h0000_0000);
		peer.idle(32);
		rd(8'h18, 32'h0000_0028, 32'h0000_0028);
		chk(tail(15), 32'h0000_007e, 32'h0000_00ff);
		// Loop station
		wb(1'b1, 8'h00, 32'h0000_0003);
		wb(1'b1, 8'h10, 32'h0000_007e);
		wb(1'b1, 8'h14, 32'h0000_0002);
		wb(1'b1, 8'h14, 32'h0000_0001);
		peer.send(8'h5a, 1'b0);
		chk(tail(8), 32'h0000_005a, 32'h0000_00ff);
		wb(1'b1, 8'h04, 32'h0000_0002);
		peer.seen_q.delete();
		peer.send(8'h7e, 1'b0);
		peer.idle(16);
		for (int i = 0; i < 24; i++) begin
			v[i] = peer.seen_q[i];
		end
		chk(v, 32'h003f_3f7e, 32'h00ff_ffff);
		wb(1'b1, 8'h1c, 32'h0000_0081);
		wb(1'b1, 8'h14, 32'h0000_0008);
		peer.idle(48);
		chk(tail(8), 32'h0000_00ff, 32'h0000_00ff);
		results;
	end
endmodule
bind hsl_station hsl_station_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.bit_stb_i(bit_stb_i), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
